// File: rtl/aidi_pkg.sv
// Shared constants and types of the analog input data interface
package aidi_pkg;

	// ****************************************
	// Clock and sampling interval
	// ****************************************
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned SAMPLE_US_1 = 20;
	localparam int unsigned SAMPLE_US_2 = 25;
	localparam int unsigned SAMPLE_US_3 = 30;
	localparam int unsigned SAMPLE_US_4 = 35;
	localparam int unsigned TIMER_W = 11;
	localparam logic [TIMER_W-1:0] SAMPLE_CYC_1 = TIMER_W'(SAMPLE_US_1 * CYC_PER_US);
	localparam logic [TIMER_W-1:0] SAMPLE_CYC_2 = TIMER_W'(SAMPLE_US_2 * CYC_PER_US);
	localparam logic [TIMER_W-1:0] SAMPLE_CYC_3 = TIMER_W'(SAMPLE_US_3 * CYC_PER_US);
	localparam logic [TIMER_W-1:0] SAMPLE_CYC_4 = TIMER_W'(SAMPLE_US_4 * CYC_PER_US);

	// ****************************************
	// Data layout
	// ****************************************
	localparam int unsigned NUM_INPUTS = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] COUNT_MAX = 3'h4;

	// Fault byte bit positions
	localparam int unsigned FAULT_SCALE_BIT = 0;
	localparam int unsigned FAULT_CFG_BIT = 1;
	localparam int unsigned FAULT_AVE_BIT = 3;
	localparam int unsigned FAULT_MODE_BIT = 4;
	localparam int unsigned FAULT_DIRECT_BIT = 5;
	localparam int unsigned FAULT_ADC_BIT = 6;

	// ****************************************
	// Setting codes
	// ****************************************
	localparam logic [7:0] RANGE_BIP10 = 8'h00;
	localparam logic [7:0] RANGE_UNI10 = 8'h02;
	localparam logic [7:0] RANGE_CUR420 = 8'h03;
	localparam logic [7:0] RANGE_BIP5 = 8'h06;
	localparam logic [7:0] RANGE_1TO5 = 8'h07;
	localparam logic [15:0] AVE_CODE_MAX = 16'h0009;
	localparam logic [7:0] MODE_CYCLIC = 8'h00;
	localparam logic [7:0] MODE_DIRECT = 8'h01;
	localparam logic signed [15:0] SCALE_HI = 16'sh7D00;
	localparam logic signed [15:0] SCALE_LO = -16'sh7D00;

	typedef enum logic [1:0] {
		AIDI_ST_LOAD = 2'b00,
		AIDI_ST_IDLE = 2'b01,
		AIDI_ST_REQ = 2'b10
	} aidi_state_e;

endpackage

// File: rtl/aidi_interval_timer.sv
// Free running interval timer that pulses once per sampling period
`timescale 1ns/100ps
module aidi_interval_timer #(
	parameter int unsigned CNT_W = aidi_pkg::TIMER_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic [CNT_W-1:0] period_i,
	output logic tick_o
);

	initial begin
		if (CNT_W < aidi_pkg::TIMER_W) begin
			$error("aidi_interval_timer: CNT_W too small for the longest interval");
		end
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic tick;
	} aidi_tmr_s;

	aidi_tmr_s st_ff;
	aidi_tmr_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!run_i) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt >= period_i - CNT_W'(1)) begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick_o = st_ff.tick;

endmodule

// File: rtl/aidi_channel.sv
// One input channel: live value, peak hold and zero when unused
`timescale 1ns/100ps
module aidi_channel #(
	parameter int unsigned DATA_W = aidi_pkg::DATA_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic sample_valid_i,
	input wire logic [DATA_W-1:0] sample_i,
	input wire logic hold_i,
	output logic [DATA_W-1:0] result_o
);

	initial begin
		if (DATA_W != aidi_pkg::DATA_W) begin
			$error("aidi_channel: result width is fixed");
		end
	end

	typedef struct packed {
		logic [DATA_W-1:0] live;
		logic [DATA_W-1:0] peak;
		logic [DATA_W-1:0] result;
	} aidi_chan_s;

	aidi_chan_s st_ff;
	aidi_chan_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (!enable_i) begin
			nxt_st = '0;
		end else if (sample_valid_i) begin
			nxt_st.live = sample_i;
			if (!hold_i || $signed(sample_i) > $signed(st_ff.peak)) begin
				nxt_st.peak = sample_i;
			end
		end else if (!hold_i) begin
			nxt_st.peak = st_ff.live;
		end
		nxt_st.result = hold_i ? nxt_st.peak : nxt_st.live;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign result_o = st_ff.result;

	property p_peak_monotonic;
		@(posedge clk_i) disable iff (!rst_n_i)
		(hold_i && enable_i && $past(hold_i) && $past(enable_i)) |->
			$signed(st_ff.result) >= $signed($past(st_ff.result));
	endproperty
	a_peak_monotonic: assert property (p_peak_monotonic) else $error("held peak decreased");

endmodule

// File: rtl/aidi_top.sv
// Analog input data interface: refresh exchange, settings load, sampling and fault flags
`timescale 1ns/100ps
module aidi_top #(
	parameter int unsigned NUM_INPUTS = aidi_pkg::NUM_INPUTS
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic restart_i,
	input wire logic refresh_i,
	input wire logic [15:0] peak_hold_request_i,
	input wire logic [7:0] active_input_count_i,
	input wire logic [NUM_INPUTS-1:0][7:0] input_range_code_i,
	input wire logic [NUM_INPUTS-1:0][15:0] averaging_code_i,
	input wire logic [NUM_INPUTS-1:0][15:0] scale_low_i,
	input wire logic [NUM_INPUTS-1:0][15:0] scale_high_i,
	input wire logic [7:0] conversion_mode_i,
	input wire logic [NUM_INPUTS-1:0] open_input_i,
	input wire logic adc_valid_i,
	input wire logic [15:0] adc_data_i,
	input wire logic adc_fail_i,
	output logic adc_req_o,
	output logic [1:0] adc_chan_o,
	output logic [15:0] channel_result1_o,
	output logic [15:0] channel_result2_o,
	output logic [15:0] channel_result3_o,
	output logic [15:0] channel_result4_o,
	output logic [15:0] peak_hold_request_o,
	output logic [7:0] open_input_flag_o,
	output logic [7:0] unit_fault_flags_o,
	output logic settings_loaded_o
);

	initial begin
		if (NUM_INPUTS != aidi_pkg::NUM_INPUTS) begin
			$error("aidi_top: the unit has exactly four inputs");
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		aidi_pkg::aidi_state_e state;
		logic [1:0] chan;
		logic [2:0] count;
		logic scale_fault;
		logic cfg_fault;
		logic ave_fault;
		logic mode_fault;
		logic direct;
		logic conv_fail;
		logic [3:0] hold;
		logic [3:0] strobe;
		logic [15:0] sample;
		logic req;
		logic [3:0] open_meta;
		logic [3:0] open_sync;
		logic [3:0][15:0] pub_result;
		logic [3:0] pub_open;
		logic [7:0] pub_fault;
		logic loaded;
	} aidi_top_s;

	aidi_top_s st_ff;
	aidi_top_s nxt_st;

	logic [3:0] chan_en;
	logic [3:0][15:0] chan_result;
	logic tick;
	logic [aidi_pkg::TIMER_W-1:0] period;
	logic [7:0] fault_byte;

	// ****************************************
	// Setting checks
	// ****************************************
	function automatic logic range_ok(input logic [7:0] code);
		logic ok;
		ok = (code == aidi_pkg::RANGE_BIP10) || (code == aidi_pkg::RANGE_UNI10) ||
			(code == aidi_pkg::RANGE_CUR420) || (code == aidi_pkg::RANGE_BIP5) ||
			(code == aidi_pkg::RANGE_1TO5);
		return ok;
	endfunction

	function automatic logic scale_bad(input logic [15:0] lo, input logic [15:0] hi);
		logic bad;
		bad = ($signed(lo) > aidi_pkg::SCALE_HI) || ($signed(lo) < aidi_pkg::SCALE_LO) ||
			($signed(hi) > aidi_pkg::SCALE_HI) || ($signed(hi) < aidi_pkg::SCALE_LO) ||
			((lo == hi) && (lo != aidi_pkg::RESULT_RST));
		return bad;
	endfunction

	// ****************************************
	// Channel enables and interval select
	// ****************************************
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			chan_en[i] = (3'(i) < st_ff.count);
		end
		case (st_ff.count)
			3'h1: period = aidi_pkg::SAMPLE_CYC_1;
			3'h2: period = aidi_pkg::SAMPLE_CYC_2;
			3'h3: period = aidi_pkg::SAMPLE_CYC_3;
			default: period = aidi_pkg::SAMPLE_CYC_4;
		endcase
	end

	// Unassigned bits stay zero
	always_comb begin
		fault_byte = aidi_pkg::BYTE_RST;
		fault_byte[aidi_pkg::FAULT_SCALE_BIT] = st_ff.scale_fault;
		fault_byte[aidi_pkg::FAULT_CFG_BIT] = st_ff.cfg_fault;
		fault_byte[aidi_pkg::FAULT_AVE_BIT] = st_ff.ave_fault;
		fault_byte[aidi_pkg::FAULT_MODE_BIT] = st_ff.mode_fault;
		fault_byte[aidi_pkg::FAULT_DIRECT_BIT] = st_ff.direct;
		fault_byte[aidi_pkg::FAULT_ADC_BIT] = st_ff.conv_fail;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.strobe = 4'h0;
		nxt_st.open_meta = open_input_i;
		nxt_st.open_sync = st_ff.open_meta;
		case (st_ff.state)
			aidi_pkg::AIDI_ST_LOAD: begin
				// Settings are sampled here and nowhere else
				nxt_st.count = (active_input_count_i > 8'(aidi_pkg::COUNT_MAX)) ? 3'h0 :
					active_input_count_i[2:0];
				nxt_st.cfg_fault = (active_input_count_i > 8'(aidi_pkg::COUNT_MAX));
				nxt_st.scale_fault = 1'b0;
				nxt_st.ave_fault = 1'b0;
				for (int i = 0; i < 4; i++) begin
					if (!range_ok(input_range_code_i[i])) begin
						nxt_st.cfg_fault = 1'b1;
					end
					if (scale_bad(scale_low_i[i], scale_high_i[i])) begin
						nxt_st.scale_fault = 1'b1;
					end
					if (averaging_code_i[i] > aidi_pkg::AVE_CODE_MAX) begin
						nxt_st.ave_fault = 1'b1;
					end
				end
				nxt_st.mode_fault = (conversion_mode_i != aidi_pkg::MODE_CYCLIC) &&
					(conversion_mode_i != aidi_pkg::MODE_DIRECT);
				nxt_st.direct = (conversion_mode_i == aidi_pkg::MODE_DIRECT);
				nxt_st.conv_fail = 1'b0;
				nxt_st.req = 1'b0;
				nxt_st.chan = 2'h0;
				nxt_st.loaded = 1'b1;
				nxt_st.state = aidi_pkg::AIDI_ST_IDLE;
			end
			aidi_pkg::AIDI_ST_IDLE: begin
				if (tick && (st_ff.count != 3'h0)) begin
					nxt_st.chan = 2'h0;
					nxt_st.req = 1'b1;
					nxt_st.state = aidi_pkg::AIDI_ST_REQ;
				end
			end
			aidi_pkg::AIDI_ST_REQ: begin
				if (adc_valid_i) begin
					nxt_st.strobe[st_ff.chan] = 1'b1;
					nxt_st.sample = adc_data_i;
					nxt_st.conv_fail = adc_fail_i;
					if (3'(st_ff.chan) + 3'h1 < st_ff.count) begin
						nxt_st.chan = st_ff.chan + 2'h1;
					end else begin
						nxt_st.req = 1'b0;
						nxt_st.state = aidi_pkg::AIDI_ST_IDLE;
					end
				end
			end
			default: begin
				nxt_st.state = aidi_pkg::AIDI_ST_LOAD;
			end
		endcase
		// Refresh exchange: take the command word, publish the data
		if (refresh_i) begin
			nxt_st.hold = peak_hold_request_i[3:0];
			nxt_st.pub_result = chan_result;
			nxt_st.pub_open = st_ff.open_sync & chan_en;
			nxt_st.pub_fault = fault_byte;
		end
		// Restart wins over the state, request and loaded updates above
		if (restart_i) begin
			nxt_st.state = aidi_pkg::AIDI_ST_LOAD;
			nxt_st.req = 1'b0;
			nxt_st.loaded = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Submodules
	// ****************************************
	aidi_interval_timer #(
		.CNT_W(aidi_pkg::TIMER_W)
	) u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.run_i(st_ff.loaded && (st_ff.count != 3'h0)),
		.period_i(period),
		.tick_o(tick)
	);

	for (genvar g = 0; g < 4; g++) begin : g_chan
		aidi_channel #(
			.DATA_W(aidi_pkg::DATA_W)
		) u_chan (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.enable_i(chan_en[g]),
			.sample_valid_i(st_ff.strobe[g]),
			.sample_i(st_ff.sample),
			.hold_i(st_ff.hold[g]),
			.result_o(chan_result[g])
		);
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign adc_req_o = st_ff.req;
	assign adc_chan_o = st_ff.chan;
	assign channel_result1_o = st_ff.pub_result[0];
	assign channel_result2_o = st_ff.pub_result[1];
	assign channel_result3_o = st_ff.pub_result[2];
	assign channel_result4_o = st_ff.pub_result[3];
	assign peak_hold_request_o = {12'h000, st_ff.hold};
	assign open_input_flag_o = {4'h0, st_ff.pub_open};
	assign unit_fault_flags_o = st_ff.pub_fault;
	assign settings_loaded_o = st_ff.loaded;

	// ****************************************
	// Assertions
	// ****************************************
	logic [aidi_pkg::TIMER_W:0] gap_cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			gap_cnt <= '0;
		end else if (!st_ff.loaded) begin
			// Timer starts at the load edge, one cycle ahead of this count
			gap_cnt <= '1;
		end else if (tick) begin
			gap_cnt <= '0;
		end else begin
			gap_cnt <= gap_cnt + 12'h001;
		end
	end

	sequence s_refresh;
		refresh_i ##1 1'b1;
	endsequence

	// Input 4 disabled by the loaded count
	sequence s_upper_unused;
		st_ff.loaded && (st_ff.count < 3'h4);
	endsequence

	property p_publish_result;
		@(posedge clk_i) disable iff (!rst_n_i)
		refresh_i |=> (channel_result1_o == $past(chan_result[0])) && (channel_result4_o == $past(chan_result[3]));
	endproperty
	a_publish_result: assert property (p_publish_result) else $error("result not published on refresh");

	property p_hold_word;
		@(posedge clk_i) disable iff (!rst_n_i)
		refresh_i |=> peak_hold_request_o == {12'h000, $past(peak_hold_request_i[3:0])};
	endproperty
	a_hold_word: assert property (p_hold_word) else $error("peak hold word not taken");

	property p_unused_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		(s_upper_unused ##1 (s_refresh and s_upper_unused [*2])) |-> channel_result4_o == aidi_pkg::RESULT_RST;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused input not zero");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		!unit_fault_flags_o[2] && !unit_fault_flags_o[7] && (open_input_flag_o[7:4] == 4'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("unassigned bit set");

	property p_interval;
		@(posedge clk_i) disable iff (!rst_n_i)
		(tick && $past(tick, 2) == 1'b0 && gap_cnt != 12'h000) |-> gap_cnt == 12'(period) - 12'h001;
	endproperty
	a_interval: assert property (p_interval) else $error("sampling interval wrong");

	property p_no_req_beyond_count;
		@(posedge clk_i) disable iff (!rst_n_i)
		adc_req_o |-> (3'(adc_chan_o) < st_ff.count);
	endproperty
	a_no_req_beyond_count: assert property (p_no_req_beyond_count) else $error("disabled input sampled");

	property p_settings_frozen;
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_ff.state != aidi_pkg::AIDI_ST_LOAD && !restart_i) |=> $stable(st_ff.count) && $stable(st_ff.direct);
	endproperty
	a_settings_frozen: assert property (p_settings_frozen) else $error("settings changed in operation");

	property p_count_fault;
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_ff.state == aidi_pkg::AIDI_ST_LOAD && !restart_i && active_input_count_i > 8'h04)
			|=> st_ff.cfg_fault && (st_ff.count == 3'h0);
	endproperty
	a_count_fault: assert property (p_count_fault) else $error("bad count not flagged");

	property p_publish_fault;
		@(posedge clk_i) disable iff (!rst_n_i)
		refresh_i |=> (unit_fault_flags_o[aidi_pkg::FAULT_CFG_BIT] == $past(st_ff.cfg_fault)) &&
			(unit_fault_flags_o[aidi_pkg::FAULT_ADC_BIT] == $past(st_ff.conv_fail));
	endproperty
	a_publish_fault: assert property (p_publish_fault) else $error("fault byte not published on refresh");

	property p_mode_flags;
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_ff.state == aidi_pkg::AIDI_ST_LOAD && !restart_i) |=>
			(st_ff.direct == $past(conversion_mode_i == aidi_pkg::MODE_DIRECT)) &&
			(st_ff.mode_fault == $past(conversion_mode_i > aidi_pkg::MODE_DIRECT));
	endproperty
	a_mode_flags: assert property (p_mode_flags) else $error("mode flags wrong");

	property p_adc_fail;
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_ff.state == aidi_pkg::AIDI_ST_REQ && adc_valid_i && !restart_i) |=> st_ff.conv_fail == $past(adc_fail_i);
	endproperty
	a_adc_fail: assert property (p_adc_fail) else $error("conversion failure not tracked");

endmodule

// File: testbench/aidi_adc_model.sv
// Behavioural converter answering the sampling requests of the block
`timescale 1ns/100ps
module aidi_adc_model #(
	parameter int unsigned DELAY = 3
) (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [1:0] chan_i,
	input wire logic [15:0] base_i,
	input wire logic fail_i,
	output logic valid_o,
	output logic [15:0] data_o,
	output logic fail_o
);
	int cnt = 0;

	initial begin
		valid_o = 1'b0;
		data_o = 16'h0000;
		fail_o = 1'b0;
	end

	// ****************************************
	// One answer per requested channel, after a delay
	// ****************************************
	always @(negedge clk_i) begin
		valid_o <= 1'b0;
		fail_o <= 1'b0;
		// Data toggles outside answers so stale values never pass
		data_o <= ~data_o;
		if (req_i && !valid_o) begin
			if (cnt == DELAY) begin
				valid_o <= 1'b1;
				data_o <= base_i + {14'h0000, chan_i};
				fail_o <= fail_i;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule

// File: testbench/tb_aidi_top.sv
// Self-checking testbench of the analog input data interface
`timescale 1ns/100ps
module tb_aidi_top;
	logic clk_i, rst_n_i, restart_i, refresh_i, adc_fail, open_any;
	logic [15:0] hold_word, base, ave, sl, sh, r1, r2, r3, r4, hold_rb;
	logic [7:0] count, mode, open_flags, faults;
	logic [31:0] rng;
	logic adc_req, adc_valid, adc_bad, loaded;
	logic [1:0] adc_chan;
	logic [15:0] adc_data;
	int mismatches = 0;
	int comparisons = 0;
	int n;

	// ****************************************
	// Clock, design and converter
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	aidi_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .restart_i(restart_i), .refresh_i(refresh_i),
		.peak_hold_request_i(hold_word), .active_input_count_i(count), .input_range_code_i(rng),
		.averaging_code_i({4{ave}}), .scale_low_i({4{sl}}), .scale_high_i({4{sh}}),
		.conversion_mode_i(mode), .open_input_i({4{open_any}}), .adc_valid_i(adc_valid),
		.adc_data_i(adc_data), .adc_fail_i(adc_bad), .adc_req_o(adc_req), .adc_chan_o(adc_chan),
		.channel_result1_o(r1), .channel_result2_o(r2), .channel_result3_o(r3),
		.channel_result4_o(r4), .peak_hold_request_o(hold_rb), .open_input_flag_o(open_flags),
		.unit_fault_flags_o(faults), .settings_loaded_o(loaded));

	aidi_adc_model adc_u (.clk_i(clk_i), .req_i(adc_req), .chan_i(adc_chan), .base_i(base),
		.fail_i(adc_fail), .valid_o(adc_valid), .data_o(adc_data), .fail_o(adc_bad));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic do_refresh(input logic [15:0] word);
		@(negedge clk_i);
		refresh_i = 1'b1;
		hold_word = word;
		@(negedge clk_i);
		refresh_i = 1'b0;
	endtask

	// Settings reach the block only at reset release or through a restart
	task automatic load();
		@(negedge clk_i);
		restart_i = 1'b1;
		@(negedge clk_i);
		restart_i = 1'b0;
		check("settings_reloading", {15'h0000, loaded}, 16'h0000);
		repeat (2) @(negedge clk_i);
		check("settings_loaded", {15'h0000, loaded}, 16'h0001);
	endtask

	// Cycles from the call to the next request start
	task automatic wait_rise(output int cyc);
		logic prior;
		prior = 1'b1;
		cyc = 0;
		while (!(adc_req === 1'b1 && prior === 1'b0)) begin
			prior = adc_req;
			@(negedge clk_i);
			cyc++;
			if (cyc > 3000) begin
				mismatches++;
				$display("CHECK FAILED request wait expected rise seen none");
				test_done();
			end
		end
	endtask

	task automatic sweep();
		wait_rise(n);
		repeat (20) @(negedge clk_i);
	endtask

	function automatic logic [15:0] period(input int c);
		case (c)
			1: return 16'(aidi_pkg::SAMPLE_CYC_1);
			2: return 16'(aidi_pkg::SAMPLE_CYC_2);
			3: return 16'(aidi_pkg::SAMPLE_CYC_3);
			default: return 16'(aidi_pkg::SAMPLE_CYC_4);
		endcase
	endfunction

	// ****************************************
	// Fault table: count, range, averaging, limits, mode, fail, flags
	// ****************************************
	typedef struct {
		logic [7:0] c; logic [31:0] r; logic [15:0] a, lo, hi; logic [7:0] m; logic f; logic [7:0] e;
	} aidi_case_s;
	aidi_case_s tbl[9] = '{
		'{8'h02, 32'h06030200, 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b0, 8'h00},
		'{8'h02, 32'h07070707, 16'h0009, 16'h8300, 16'h7D00, 8'h00, 1'b0, 8'h00},
		'{8'h02, 32'h06030200, 16'h0000, 16'h0064, 16'h0064, 8'h00, 1'b0, 8'h01},
		'{8'h02, 32'h06030201, 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b0, 8'h02},
		'{8'h05, 32'h06030200, 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b0, 8'h02},
		'{8'h02, 32'h06030200, 16'h000A, 16'h0000, 16'h0000, 8'h00, 1'b0, 8'h08},
		'{8'h02, 32'h06030200, 16'h0000, 16'h0000, 16'h0000, 8'h02, 1'b0, 8'h10},
		'{8'h02, 32'h06030200, 16'h0000, 16'h0000, 16'h0000, 8'h01, 1'b0, 8'h20},
		'{8'h02, 32'h06030200, 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b1, 8'h40}
	};

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n_i = 1'b0;
		restart_i = 1'b0;
		refresh_i = 1'b0;
		hold_word = 16'h0000;
		count = 8'h02;
		rng = 32'h06030200;
		ave = 16'h0000;
		sl = 16'h0000;
		sh = 16'h0000;
		mode = 8'h00;
		open_any = 1'b0;
		adc_fail = 1'b0;
		base = 16'h1000;
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		foreach (tbl[i]) begin
			{count, rng, ave, sl, sh, mode, adc_fail} = {tbl[i].c, tbl[i].r, tbl[i].a, tbl[i].lo,
				tbl[i].hi, tbl[i].m, tbl[i].f};
			load();
			if (tbl[i].f) begin
				sweep();
			end
			do_refresh(16'h0000);
			check("unit_fault_flags", {8'h00, faults}, {8'h00, tbl[i].e});
		end
		{mode, adc_fail} = {8'h00, 1'b0};
		for (int c = 1; c <= 4; c++) begin
			count = 8'(c);
			load();
			wait_rise(n);
			wait_rise(n);
			check("sample_period", 16'(n), period(c));
		end
		count = 8'h01;
		wait_rise(n);
		wait_rise(n);
		check("period_unchanged", 16'(n), period(4));
		count = 8'h02;
		load();
		open_any = 1'b1;
		sweep();
		do_refresh(16'hFFF1);
		check("result1", r1, 16'h1000);
		check("result2", r2, 16'h1001);
		check("result3", r3, 16'h0000);
		check("result4", r4, 16'h0000);
		check("hold_readback", hold_rb, 16'h0001);
		check("open_flags", {8'h00, open_flags}, 16'h0003);
		base = 16'h0100;
		sweep();
		do_refresh(16'h0001);
		check("held_result1", r1, 16'h1000);
		check("live_result2", r2, 16'h0101);
		do_refresh(16'h0000);
		sweep();
		do_refresh(16'h0000);
		check("released_result1", r1, 16'h0100);
		check("hold_cleared", hold_rb, 16'h0000);
		test_done();
	end
endmodule
